// ==== core/atten_cfg_pkg.sv ====
package atten_cfg_pkg;

  // ==========================================================
  // Register indices as printed (byte address = 4 * index)
  localparam logic [7:0] IDX_START_PERIOD_WAIT = 8'hB7;
  localparam logic [7:0] IDX_FIXED_ATTEN_0_1 = 8'hB9;
  localparam logic [7:0] IDX_FIXED_ATTEN_2_3 = 8'hBA;
  localparam logic [7:0] IDX_GAIN_CONTROL = 8'hC0;
  localparam logic [7:0] IDX_ATTEN_STATUS = 8'hC1;

  // ==========================================================
  // Reset values
  localparam logic [15:0] RESET_VALUE = 16'h0000;

  // ==========================================================
  // Field positions in the fixed attenuation registers
  localparam int HI_EN_BIT = 15;
  localparam int HI_CODE_LSB = 8;
  localparam int LO_EN_BIT = 7;
  localparam int LO_CODE_LSB = 0;
  localparam int CODE_WIDTH = 7;

  // Field positions in the gain control register
  localparam int CTL_TERM_LSB = 0;
  localparam int CTL_INT_START_BIT = 4;
  localparam int CTL_OVERRIDE_BIT = 5;
  localparam int CTL_PROFILE_LSB = 6;
  localparam int CTL_DISABLE_BIT = 8;

  // Termination code that leaves the input open
  localparam logic [3:0] TERM_OPEN = 4'hF;

  // Start pulse sequencer states
  typedef enum logic [0:0]
  {
    ST_IDLE = 1'b0,
    ST_COUNT = 1'b1
  } start_state_t;

  // Attenuator setting handed to the analog side
  typedef struct packed
  {
    logic active;
    logic fixed;
    logic [6:0] code;
    logic [3:0] term;
    logic term_open;
  } atten_setting_t;

endpackage

// ==== core/tgc_attenuator_config_regs.sv ====
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/10ps
module tgc_attenuator_config_regs
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [9:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  output logic [1:0] RESPONSE,
  input wire logic [1:0] PROFILE_SELECT_PINS,
  input wire logic EXT_START,
  output logic CURVE_START,
  output atten_cfg_pkg::atten_setting_t ATTEN_SETTING,
  output logic [1:0] ACTIVE_PROFILE
);

  // ==========================================================
  // Registers
  logic [15:0] start_period_wait;
  logic [15:0] fixed_atten_profiles_0_1;
  logic [15:0] fixed_atten_profiles_2_3;
  logic [8:0] gain_control;
  logic [31:0] read_data;
  logic [1:0] response;
  logic ack;
  logic [1:0] pins_meta;
  logic [1:0] pins_sync;
  logic ext_meta;
  logic ext_sync;
  logic [15:0] wait_count;
  atten_cfg_pkg::start_state_t start_state;
  logic start_pulse;
  atten_cfg_pkg::atten_setting_t setting;
  logic [1:0] profile;

  logic [15:0] next_start_period_wait;
  logic [15:0] next_fixed_atten_profiles_0_1;
  logic [15:0] next_fixed_atten_profiles_2_3;
  logic [8:0] next_gain_control;
  logic [31:0] next_read_data;
  logic [1:0] next_response;
  logic next_ack;
  logic [15:0] next_wait_count;
  atten_cfg_pkg::start_state_t next_start_state;
  logic next_start_pulse;
  atten_cfg_pkg::atten_setting_t next_setting;
  logic [1:0] next_profile;

  logic [7:0] index;
  logic word_ok;
  logic hit;
  logic [15:0] lane_mask;
  logic int_start_en;
  logic [6:0] sel_code;
  logic sel_enable;

  // ==========================================================
  // Bus decode
  assign index = ADDRESS[9:2];
  assign word_ok = (ADDRESS[1:0] == 2'b00);
  assign lane_mask = {{8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};
  assign WAITREQUEST = (READ | WRITE) & ~ack;
  assign int_start_en = gain_control[atten_cfg_pkg::CTL_INT_START_BIT];

  // Address hit check
  always_comb
  begin
    hit = 1'b0;
    if (word_ok)
    begin
      unique case (index)
        atten_cfg_pkg::IDX_START_PERIOD_WAIT,
        atten_cfg_pkg::IDX_FIXED_ATTEN_0_1,
        atten_cfg_pkg::IDX_FIXED_ATTEN_2_3,
        atten_cfg_pkg::IDX_GAIN_CONTROL,
        atten_cfg_pkg::IDX_ATTEN_STATUS: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end

  // Register writes, reads and one-cycle acknowledge
  always_comb
  begin
    next_start_period_wait = start_period_wait;
    next_fixed_atten_profiles_0_1 = fixed_atten_profiles_0_1;
    next_fixed_atten_profiles_2_3 = fixed_atten_profiles_2_3;
    next_gain_control = gain_control;
    next_read_data = read_data;
    next_response = response;
    next_ack = 1'b0;
    if ((READ | WRITE) & ~ack)
    begin
      next_ack = 1'b1;
      next_response = hit ? 2'b00 : 2'b10;
      next_read_data = 32'h0000_0000;
      if (WRITE & hit)
      begin
        unique case (index)
          atten_cfg_pkg::IDX_START_PERIOD_WAIT:
            next_start_period_wait = (start_period_wait & ~lane_mask)
              | (WRITEDATA[15:0] & lane_mask);
          atten_cfg_pkg::IDX_FIXED_ATTEN_0_1:
            next_fixed_atten_profiles_0_1 =
              (fixed_atten_profiles_0_1 & ~lane_mask)
              | (WRITEDATA[15:0] & lane_mask);
          atten_cfg_pkg::IDX_FIXED_ATTEN_2_3:
            next_fixed_atten_profiles_2_3 =
              (fixed_atten_profiles_2_3 & ~lane_mask)
              | (WRITEDATA[15:0] & lane_mask);
          atten_cfg_pkg::IDX_GAIN_CONTROL:
            next_gain_control = (gain_control & ~lane_mask[8:0])
              | (WRITEDATA[8:0] & lane_mask[8:0]);
          default:
            next_gain_control = gain_control; // Status is read only
        endcase
      end
      if (READ & hit)
      begin
        unique case (index)
          atten_cfg_pkg::IDX_START_PERIOD_WAIT:
            next_read_data = {16'h0000, start_period_wait};
          atten_cfg_pkg::IDX_FIXED_ATTEN_0_1:
            next_read_data = {16'h0000, fixed_atten_profiles_0_1};
          atten_cfg_pkg::IDX_FIXED_ATTEN_2_3:
            next_read_data = {16'h0000, fixed_atten_profiles_2_3};
          atten_cfg_pkg::IDX_GAIN_CONTROL:
            next_read_data = {23'h00_0000, gain_control};
          default:
            next_read_data = {16'h0000, profile, setting};
        endcase
      end
    end
  end

  // ==========================================================
  // Start pulse generator
  always_comb
  begin
    next_wait_count = wait_count;
    next_start_state = start_state;
    next_start_pulse = 1'b0;
    unique case (start_state)
      atten_cfg_pkg::ST_IDLE:
      begin
        next_wait_count = 16'h0000;
        if (int_start_en)
        begin
          next_start_state = atten_cfg_pkg::ST_COUNT;
          next_start_pulse = 1'b1;
        end
      end
      atten_cfg_pkg::ST_COUNT:
      begin
        if (!int_start_en)
        begin
          next_start_state = atten_cfg_pkg::ST_IDLE;
        end
        else if (wait_count >= start_period_wait)
        begin
          next_wait_count = 16'h0000;
          next_start_pulse = 1'b1;
        end
        else
        begin
          next_wait_count = wait_count + 16'h0001;
        end
      end
    endcase
  end

  // Start source select
  assign CURVE_START = int_start_en ? start_pulse : ext_sync;

  // ==========================================================
  // Profile selection and attenuator setting
  always_comb
  begin
    if (gain_control[atten_cfg_pkg::CTL_OVERRIDE_BIT])
    begin
      next_profile = gain_control[atten_cfg_pkg::CTL_PROFILE_LSB +: 2];
    end
    else
    begin
      next_profile = pins_sync;
    end
  end

  // Pick the active profile's enable and code
  always_comb
  begin
    unique case (profile)
      2'd0:
      begin
        sel_enable = fixed_atten_profiles_0_1[atten_cfg_pkg::HI_EN_BIT];
        sel_code = fixed_atten_profiles_0_1[atten_cfg_pkg::HI_CODE_LSB
          +: atten_cfg_pkg::CODE_WIDTH];
      end
      2'd1:
      begin
        sel_enable = fixed_atten_profiles_0_1[atten_cfg_pkg::LO_EN_BIT];
        sel_code = fixed_atten_profiles_0_1[atten_cfg_pkg::LO_CODE_LSB
          +: atten_cfg_pkg::CODE_WIDTH];
      end
      2'd2:
      begin
        sel_enable = fixed_atten_profiles_2_3[atten_cfg_pkg::HI_EN_BIT];
        sel_code = fixed_atten_profiles_2_3[atten_cfg_pkg::HI_CODE_LSB
          +: atten_cfg_pkg::CODE_WIDTH];
      end
      default:
      begin
        sel_enable = fixed_atten_profiles_2_3[atten_cfg_pkg::LO_EN_BIT];
        sel_code = fixed_atten_profiles_2_3[atten_cfg_pkg::LO_CODE_LSB
          +: atten_cfg_pkg::CODE_WIDTH];
      end
    endcase
  end

  // Setting; code N stands for -8 dB + N * 0.125 dB
  always_comb
  begin
    next_setting.active =
      ~gain_control[atten_cfg_pkg::CTL_DISABLE_BIT];
    next_setting.fixed = sel_enable;
    next_setting.code = sel_enable ? sel_code : 7'h00;
    next_setting.term =
      gain_control[atten_cfg_pkg::CTL_TERM_LSB +: 4];
    next_setting.term_open = (next_setting.term
      == atten_cfg_pkg::TERM_OPEN);
  end

  // ==========================================================
  // State registers
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      start_period_wait <= atten_cfg_pkg::RESET_VALUE;
      fixed_atten_profiles_0_1 <= atten_cfg_pkg::RESET_VALUE;
      fixed_atten_profiles_2_3 <= atten_cfg_pkg::RESET_VALUE;
      gain_control <= 9'h000;
      read_data <= 32'h0000_0000;
      response <= 2'b00;
      ack <= 1'b0;
      pins_meta <= 2'b00;
      pins_sync <= 2'b00;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      wait_count <= 16'h0000;
      start_state <= atten_cfg_pkg::ST_IDLE;
      start_pulse <= 1'b0;
      setting <= '0;
      profile <= 2'b00;
    end
    else
    begin
      start_period_wait <= next_start_period_wait;
      fixed_atten_profiles_0_1 <= next_fixed_atten_profiles_0_1;
      fixed_atten_profiles_2_3 <= next_fixed_atten_profiles_2_3;
      gain_control <= next_gain_control;
      read_data <= next_read_data;
      response <= next_response;
      ack <= next_ack;
      pins_meta <= PROFILE_SELECT_PINS;
      pins_sync <= pins_meta;
      ext_meta <= EXT_START;
      ext_sync <= ext_meta;
      wait_count <= next_wait_count;
      start_state <= next_start_state;
      start_pulse <= next_start_pulse;
      setting <= next_setting;
      profile <= next_profile;
    end
  end

  // Outputs
  assign READDATA = read_data;
  assign RESPONSE = response;
  assign ATTEN_SETTING = setting;
  assign ACTIVE_PROFILE = profile;

endmodule

// ==== dv/tgc_attenuator_config_regs_assertions.sv ====
`timescale 1ns/10ps
// =====================================================
// Port checks for the attenuator register bank
module atten_cfg_checker
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [9:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST,
  input wire logic [1:0] RESPONSE,
  input wire logic [1:0] PROFILE_SELECT_PINS,
  input wire logic CURVE_START,
  input wire atten_cfg_pkg::atten_setting_t ATTEN_SETTING,
  input wire logic [1:0] ACTIVE_PROFILE
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  // Setting and profile outputs
  term_open_a:
    assert property (ATTEN_SETTING.term_open ==
      (ATTEN_SETTING.term == atten_cfg_pkg::TERM_OPEN)) else $error("open");
  code_gate_a:
    assert property (!ATTEN_SETTING.fixed |-> ATTEN_SETTING.code == 7'h00)
      else $error("code leaks");
  profile_hold_a:
    assert property ((!WRITE && $stable(PROFILE_SELECT_PINS)) [*5]
      |-> $stable(ACTIVE_PROFILE)) else $error("profile moved");
  setting_hold_a:
    assert property ((!WRITE && $stable(PROFILE_SELECT_PINS)) [*6]
      |-> $stable(ATTEN_SETTING)) else $error("setting moved");
  term_hold_a:
    assert property (!WRITE [*3] |-> $stable(ATTEN_SETTING.term))
      else $error("term moved");
  // Bus answers
  bus_wait_a:
    assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
      else $error("no answer");
  bad_addr_a:
    assert property ((READ || WRITE) && !WAITREQUEST && ADDRESS[1:0] != 2'b00
      |-> RESPONSE == 2'b10) else $error("no error code");
  upper_zero_a:
    assert property (READ && !WAITREQUEST |-> READDATA[31:16] == 16'h0000)
      else $error("upper bits");
  cover property (ATTEN_SETTING.fixed);
  cover property (ATTEN_SETTING.term_open);
  cover property (CURVE_START ##1 CURVE_START);
  cover property (RESPONSE == 2'b10);
endmodule

// ==== dv/tgc_attenuator_config_regs_bench.sv ====
`timescale 1ns/10ps
// =====================================================
// Self-checking bench
module tgc_attenuator_config_regs_bench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [9:0] addr = 10'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [1:0] pins = 2'b00;
  logic [3:0] be = 4'hF;
  logic ext = 1'b0;
  logic [31:0] rdata_o;
  logic wait_o;
  logic [1:0] resp_o;
  logic start_o;
  atten_cfg_pkg::atten_setting_t set_o;
  logic [1:0] prof_o;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic [1:0] pv;
  logic [15:0] fix01;
  logic [15:0] fix23;
  logic [15:0] shadow [3];
  logic [7:0] regs [3] = '{atten_cfg_pkg::IDX_START_PERIOD_WAIT,
    atten_cfg_pkg::IDX_FIXED_ATTEN_0_1, atten_cfg_pkg::IDX_FIXED_ATTEN_2_3};
  logic [7:0] ctl = atten_cfg_pkg::IDX_GAIN_CONTROL;
  logic dis = 1'b0;
  integer seed = 3249;
  int mismatches = 0;
  int checked = 0;
  int gap;

  // Clock
  always #12.5 clk = ~clk;

  tgc_attenuator_config_regs tgc_attenuator_config_regs_i
  (
    .CLK(clk), .RESETN(resetn), .ADDRESS(addr), .READ(rd), .WRITE(wr),
    .WRITEDATA(wdata), .BYTEENABLE(be), .READDATA(rdata_o),
    .WAITREQUEST(wait_o), .RESPONSE(resp_o), .PROFILE_SELECT_PINS(pins),
    .EXT_START(ext), .CURVE_START(start_o), .ATTEN_SETTING(set_o),
    .ACTIVE_PROFILE(prof_o)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] i, input logic [1:0] lo,
    input logic [15:0] d);
    int n;
    @(posedge clk);
    addr <= {i, lo};
    rd <= !w;
    wr <= w;
    wdata <= {16'hFFFF, d};
    n = 0;
    // Sample waitrequest and read data at rising edges only
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_o !== 1'b0 && n < 20);
    if (wait_o !== 1'b0)
    begin
      mismatches++;
      end_of_test();
    end
    else
    begin
      rdata = rdata_o;
      rresp = resp_o;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask

  function automatic atten_cfg_pkg::atten_setting_t want(input logic [1:0] p,
    input logic [3:0] t);
    logic [15:0] r;
    atten_cfg_pkg::atten_setting_t s;
    r = p[1] ? fix23 : fix01;
    s.fixed = p[0] ? r[7] : r[15];
    s.code = !s.fixed ? 7'h00 : p[0] ? r[6:0] : r[14:8];
    s.active = !dis;
    s.term = t;
    s.term_open = (t == 4'hF);
    return s;
  endfunction

  task automatic cmp_set(input logic [1:0] p, input logic [3:0] t);
    atten_cfg_pkg::atten_setting_t s;
    s = want(p, t);
    repeat (6) @(negedge clk);
    check({30'h0, prof_o}, {30'h0, p});
    check({23'h0, set_o[13:5]}, {23'h0, s[13:5]});
    check({27'h0, set_o[4:0]}, {27'h0, s[4:0]});
  endtask

  // Count pulses over a fixed window
  task automatic count(input int n, output int c);
    c = 0;
    repeat (n)
    begin
      @(negedge clk);
      if (start_o === 1'b1)
        c++;
    end
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    // Reset values and random write, read back
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b0, regs[i], 2'b00, 16'h0000);
      check(rdata, 32'h0000_0000);
      for (int j = 0; j < 4; j++)
      begin
        shadow[i] = (j == 0) ? 16'hFFFF : 16'($random(seed));
        bus(1'b1, regs[i], 2'b00, shadow[i]);
        bus(1'b0, regs[i], 2'b00, 16'h0000);
        check(rdata, {16'h0000, shadow[i]});
      end
    end
    // Unmapped read and unaligned write
    bus(1'b0, 8'h10, 2'b00, 16'h0000);
    check({rresp, rdata[29:0]}, 32'h8000_0000);
    bus(1'b1, regs[1], 2'b10, 16'h5A5A);
    check({30'h0, rresp}, 32'h0000_0002);
    bus(1'b0, regs[1], 2'b00, 16'h0000);
    check(rdata, {16'h0000, shadow[1]});
    // Low byte lane only
    be <= 4'h1;
    bus(1'b1, regs[1], 2'b00, 16'hA5A5);
    be <= 4'hF;
    bus(1'b0, regs[1], 2'b00, 16'h0000);
    check(rdata, {16'h0000, shadow[1][15:8], 8'hA5});
    // Every termination code, profile from register field
    for (int i = 0; i < 16; i++)
    begin
      fix01 = 16'($random(seed));
      fix23 = 16'($random(seed));
      dis = 1'($random(seed));
      bus(1'b1, regs[1], 2'b00, fix01);
      bus(1'b1, regs[2], 2'b00, fix23);
      bus(1'b1, ctl, 2'b00, {7'h00, dis, 2'(i), 2'b10, 4'(i)});
      cmp_set(2'(i), 4'(i));
      bus(1'b0, atten_cfg_pkg::IDX_ATTEN_STATUS, 2'b00, 16'h0000);
      check(rdata, {16'h0000, 2'(i), want(2'(i), 4'(i))});
    end
    // Profile from pins
    dis = 1'b0;
    bus(1'b1, ctl, 2'b00, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      pv = 2'($random(seed));
      pins <= pv;
      cmp_set(pv, 4'h0);
    end
    // Internal start period
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, regs[0], 2'b00, 16'(i * i * 3));
      bus(1'b1, ctl, 2'b00, 16'h0010);
      // Three periods hold exactly three pulses
      count((i * i * 3 + 1) * 3, gap);
      check(gap, 3);
      gap = 0;
      while (start_o !== 1'b1 && gap < 40)
      begin
        @(negedge clk);
        gap++;
      end
      gap = 0;
      repeat (40)
      begin
        @(negedge clk);
        gap++;
        if (start_o === 1'b1)
          break;
      end
      check(gap, i * i * 3 + 1);
      bus(1'b1, ctl, 2'b00, 16'h0000);
    end
    // External start only
    repeat (4) @(posedge clk);
    count(20, gap);
    check(gap, 0);
    ext <= 1'b1;
    @(posedge clk);
    ext <= 1'b0;
    count(8, gap);
    check(gap, 1);
    end_of_test();
  end
endmodule

bind tgc_attenuator_config_regs atten_cfg_checker atten_cfg_checker_i
(
  .CLK(CLK), .RESETN(RESETN), .ADDRESS(ADDRESS), .READ(READ),
  .WRITE(WRITE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
  .RESPONSE(RESPONSE), .PROFILE_SELECT_PINS(PROFILE_SELECT_PINS),
  .CURVE_START(CURVE_START), .ATTEN_SETTING(ATTEN_SETTING),
  .ACTIVE_PROFILE(ACTIVE_PROFILE)
);
